//--- src/reader_tx_rx_timing.sv
// reader tx/rx timing: delay timer, pulse length, no-response timer
// assumes classic wishbone master on clk_sys; frame events on same clock
// chip_enable arrives from a pin and is synchronised here
//
// Function
// - register 0x05 is delay length low byte
// - delay counts 590 ns steps, 1..16383
// - zero length disables delayed transmission
// - reset, disable, protocol write load defaults
// - zero pulse register uses protocol preset
// - nonzero pulse register gives value times 73.7 ns, except at 848 kbps
// - protocol presets modulation pulse length
// - no response sets irq status flag
// - no-response value counts 37.76 us steps
// - measure from tx EOF end to response
// - protocol presets no-response time
// - fifo reset after tx complete disables detection
// - no-response interrupt only in vicinity mode
// - register 0x04 holds high bits, start select
`timescale 1ns/1ps
module reader_tx_rx_timing
    import rtt_pkg::*;
#(
    parameter int NO_RESP_STEP_CYC = NO_RESP_STEP_CYC_DEF
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // chip enable pin, low disables the chip
    input wire logic chip_enable,
    // frame events from the framer, one-cycle pulses
    input wire logic tx_sof_begin,
    input wire logic tx_sof_end,
    input wire logic rx_sof_begin,
    input wire logic rx_sof_end,
    input wire logic tx_eof_end,
    input wire logic tx_complete,
    input wire logic tx_mod_request,
    // results
    output logic delayed_tx_start,
    output logic tx_mod_pulse,
    output logic irq
);

    // =====================================================
    // registers
    logic [7:0] protocol_ctrl;            // low bits select protocol
    logic [7:0] tx_delay_timer_high;      // start select and length top
    logic [7:0] tx_delay_timer_low;       // length low byte
    logic [7:0] tx_pulse_length_override;
    logic [7:0] no_response_wait_time;
    logic [1:0] irq_status;               // sticky, write one to clear
    logic [1:0] irq_mask;                 // one lets the bit through

    // chip enable synchroniser
    logic en_meta;
    logic en_sync;

    // detection gate for the current exchange
    logic tx_done_seen;     // a tx complete passed this exchange
    logic no_resp_off;      // fifo reset after tx complete
    logic rx_response;      // wait stop: response start, gate off or defaults load

    // bus decode
    logic bus_req;
    logic bus_wr;
    logic wr_protocol;
    logic load_defaults;

    // timers
    logic delay_start;
    logic delay_expired;
    logic no_resp_start;
    logic no_resp_expired;
    logic [12:0] pulse_cyc;
    protocol_t proto;
    start_sel_t start_sel;

    // =====================================================
    // decoding used for reads and for writes
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] i);
        is_reg = (a[7:2] == i[5:0]) && (a[1:0] == 2'b00);
    endfunction

    // preset of the no-response value for a protocol code
    function automatic logic [7:0] no_resp_preset(input protocol_t p);
        unique case (p)
            PROTO_VICINITY_HIGH: no_resp_preset = NO_RESP_VIC_HIGH;
            PROTO_VICINITY_LOW: no_resp_preset = NO_RESP_VIC_LOW;
            default: no_resp_preset = NO_RESP_OTHER;
        endcase
    endfunction

    // =====================================================
    // pin synchroniser; only the second stage is read
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end
        else
        begin
            en_meta <= chip_enable;
            en_sync <= en_meta;
        end
    end

    // =====================================================
    // bus request decode
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign wr_protocol = bus_wr && is_reg(wb_adr_i, IDX_PROTOCOL_CTRL);
    assign proto = protocol_t'(protocol_ctrl[2:0]);
    assign start_sel = start_sel_t'(tx_delay_timer_high[HIGH_START_SEL_POS +: 2]);
    // chip disabled holds the defaults
    assign load_defaults = !en_sync || wr_protocol;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= bus_req;
        end
    end

    // read mux; unmapped addresses read as zero and still ack
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (bus_req && !wb_we_i)
        begin
            wb_dat_o <= 32'h0000_0000;
            if (is_reg(wb_adr_i, IDX_PROTOCOL_CTRL))
                wb_dat_o[7:0] <= protocol_ctrl;
            else if (is_reg(wb_adr_i, IDX_TX_DELAY_HIGH))
                wb_dat_o[7:0] <= tx_delay_timer_high;
            else if (is_reg(wb_adr_i, IDX_TX_DELAY_LOW))
                wb_dat_o[7:0] <= tx_delay_timer_low;
            else if (is_reg(wb_adr_i, IDX_PULSE_LENGTH))
                wb_dat_o[7:0] <= tx_pulse_length_override;
            else if (is_reg(wb_adr_i, IDX_NO_RESPONSE))
                wb_dat_o[7:0] <= no_response_wait_time;
            else if (is_reg(wb_adr_i, IDX_IRQ_STATUS))
                wb_dat_o[1:0] <= irq_status;
            else if (is_reg(wb_adr_i, IDX_IRQ_MASK))
                wb_dat_o[1:0] <= irq_mask;
        end
    end

    // =====================================================
    // protocol selection register; kept while chip disabled
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            protocol_ctrl <= RST_PROTOCOL_CTRL;
        end
        else if (wr_protocol)
        begin
            protocol_ctrl <= wb_dat_i[7:0];
        end
    end

    // timing registers; defaults win over a plain write
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_delay_timer_high <= RST_TX_DELAY_HIGH;
            tx_delay_timer_low <= RST_TX_DELAY_LOW;
            tx_pulse_length_override <= RST_PULSE_LENGTH;
            no_response_wait_time <= RST_NO_RESPONSE;
        end
        else if (load_defaults)
        begin
            tx_delay_timer_high <= RST_TX_DELAY_HIGH;
            tx_delay_timer_low <= RST_TX_DELAY_LOW;
            tx_pulse_length_override <= RST_PULSE_LENGTH;
            // a protocol write presets from the new protocol code
            if (wr_protocol && en_sync)
                no_response_wait_time <= no_resp_preset(protocol_t'(wb_dat_i[2:0]));
            else
                no_response_wait_time <= RST_NO_RESPONSE;
        end
        else if (bus_wr)
        begin
            if (is_reg(wb_adr_i, IDX_TX_DELAY_HIGH))
                tx_delay_timer_high <= wb_dat_i[7:0];
            if (is_reg(wb_adr_i, IDX_TX_DELAY_LOW))
                tx_delay_timer_low <= wb_dat_i[7:0];
            if (is_reg(wb_adr_i, IDX_PULSE_LENGTH))
                tx_pulse_length_override <= wb_dat_i[7:0];
            if (is_reg(wb_adr_i, IDX_NO_RESPONSE))
                no_response_wait_time <= wb_dat_i[7:0];
        end
    end

    // interrupt mask
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_mask <= RST_IRQ_MASK[1:0];
        end
        else if (bus_wr && is_reg(wb_adr_i, IDX_IRQ_MASK))
        begin
            irq_mask <= wb_dat_i[1:0];
        end
    end

    // sticky status; a new event wins over the clear in one cycle
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_status <= 2'b00;
        end
        else
        begin
            if (bus_wr && is_reg(wb_adr_i, IDX_IRQ_STATUS))
                irq_status <= irq_status & ~wb_dat_i[1:0];
            if (no_resp_expired)
                irq_status[STAT_NO_RESPONSE_POS] <= 1'b1;
            if (delay_expired)
                irq_status[STAT_DELAY_FIRED_POS] <= 1'b1;
        end
    end

    // level interrupt, registered
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // =====================================================
    // delayed transmission timer
    // start condition picks which frame event loads the count
    always_comb
    begin
        unique case (start_sel)
            START_TX_SOF_BEGIN: delay_start = tx_sof_begin;
            START_TX_SOF_END: delay_start = tx_sof_end;
            START_RX_SOF_BEGIN: delay_start = rx_sof_begin;
            START_RX_SOF_END: delay_start = rx_sof_end;
        endcase
    end

    // length zero never starts, so the timer is disabled
    step_timer delay_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(delay_start),
        .stop(load_defaults),
        .length({tx_delay_timer_high[5:0], tx_delay_timer_low}),
        .step_cyc(16'(DELAY_STEP_CYC)),
        .busy(),
        .expired(delay_expired)
    );

    // trigger of the pending transmission
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            delayed_tx_start <= 1'b0;
        end
        else
        begin
            delayed_tx_start <= delay_expired;
        end
    end

    // =====================================================
    // modulation pulse width
    always_comb
    begin
        // the override has no effect at 848 kbps
        if (tx_pulse_length_override != 8'h00 && proto != PROTO_TYPE_A_848)
        begin
            // override in 73.7 ns units
            pulse_cyc = 13'(tx_pulse_length_override * PULSE_STEP_CYC);
        end
        else
        begin
            unique case (proto)
                PROTO_TYPE_A_106: pulse_cyc = PULSE_A106_CYC;
                PROTO_TYPE_A_212: pulse_cyc = PULSE_A212_CYC;
                PROTO_TYPE_A_424: pulse_cyc = PULSE_A424_CYC;
                PROTO_TYPE_A_848: pulse_cyc = PULSE_A848_CYC;
                default: pulse_cyc = PULSE_VICINITY_CYC;
            endcase
        end
    end

    pulse_shaper mod_shaper (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .fire(tx_mod_request),
        .width_cyc(pulse_cyc),
        .mod_out(tx_mod_pulse)
    );

    // =====================================================
    // exchange gate: fifo reset after tx complete turns detection off
    // until the next frame begins
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_done_seen <= 1'b0;
            no_resp_off <= 1'b0;
        end
        else if (tx_sof_begin)
        begin
            tx_done_seen <= 1'b0;
            no_resp_off <= 1'b0;
        end
        else
        begin
            if (tx_complete)
                tx_done_seen <= 1'b1;
            if (bus_wr && is_reg(wb_adr_i, IDX_COMMAND)
                && wb_dat_i[7:0] == CMD_FIFO_RESET && tx_done_seen)
                no_resp_off <= 1'b1;
        end
    end

    // vicinity modes only
    assign no_resp_start = tx_eof_end && !no_resp_off
        && (proto == PROTO_VICINITY_LOW || proto == PROTO_VICINITY_HIGH);
    // a response start or a turned-off gate ends the wait
    assign rx_response = rx_sof_begin || no_resp_off || load_defaults;

    step_timer no_resp_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(no_resp_start),
        .stop(rx_response),
        .length({6'b00_0000, no_response_wait_time}),
        .step_cyc(16'(NO_RESP_STEP_CYC)),
        .busy(),
        .expired(no_resp_expired)
    );

endmodule // reader_tx_rx_timing

//--- src/rtt_pkg.sv
// constants shared by the reader tx/rx timing block and its helpers
// assumes a single 250 MHz system clock; times are kept in picoseconds
package rtt_pkg;

    // =====================================================
    // clock
    localparam int CLK_PERIOD_PS = 4000;

    // =====================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_PROTOCOL_CTRL = 8'h01;
    localparam logic [7:0] IDX_TX_DELAY_HIGH = 8'h04;
    localparam logic [7:0] IDX_TX_DELAY_LOW = 8'h05;
    localparam logic [7:0] IDX_PULSE_LENGTH = 8'h06;
    localparam logic [7:0] IDX_NO_RESPONSE = 8'h07;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h0D;
    localparam logic [7:0] IDX_COMMAND = 8'h0E;

    // =====================================================
    // values after reset; delay and pulse ones also after chip disable and protocol write, no-response after disable
    localparam logic [7:0] RST_PROTOCOL_CTRL = 8'h00;
    localparam logic [7:0] RST_TX_DELAY_HIGH = 8'hC2;
    localparam logic [7:0] RST_TX_DELAY_LOW = 8'h00;
    localparam logic [7:0] RST_PULSE_LENGTH = 8'h00;
    localparam logic [7:0] RST_NO_RESPONSE = 8'h0E;
    localparam logic [7:0] RST_IRQ_MASK = 8'h00;

    // =====================================================
    // field positions
    localparam int HIGH_START_SEL_POS = 6;    // two start select bits
    localparam int STAT_NO_RESPONSE_POS = 0;
    localparam int STAT_DELAY_FIRED_POS = 1;
    localparam logic [7:0] CMD_FIFO_RESET = 8'h0F;

    // =====================================================
    // protocol codes in the protocol control register, low three bits
    typedef enum logic [2:0] {
        PROTO_VICINITY_LOW,
        PROTO_VICINITY_HIGH,
        PROTO_TYPE_A_106,
        PROTO_TYPE_A_212,
        PROTO_TYPE_A_424,
        PROTO_TYPE_A_848,
        PROTO_OTHER_6,
        PROTO_OTHER_7
    } protocol_t;

    // start condition of the delay timer
    typedef enum logic [1:0] {
        START_TX_SOF_BEGIN,
        START_TX_SOF_END,
        START_RX_SOF_BEGIN,
        START_RX_SOF_END
    } start_sel_t;

    // =====================================================
    // step times and derived cycle counts (least times round up)
    localparam int DELAY_STEP_PS = 590_000;
    localparam int DELAY_STEP_CYC = (DELAY_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_STEP_PS = 73_700;
    localparam int PULSE_STEP_CYC = (PULSE_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int NO_RESP_STEP_PS = 37_760_000;
    localparam int NO_RESP_STEP_CYC_DEF = NO_RESP_STEP_PS / CLK_PERIOD_PS;

    // protocol presets of the modulation pulse
    localparam int PULSE_VICINITY_PS = 9_440_000;
    localparam int PULSE_A106_PS = 2_360_000;
    localparam int PULSE_A212_PS = 1_400_000;
    localparam int PULSE_A424_PS = 737_000;
    localparam int PULSE_A848_PS = 442_000;
    localparam logic [12:0] PULSE_VICINITY_CYC = 13'((PULSE_VICINITY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [12:0] PULSE_A106_CYC = 13'((PULSE_A106_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [12:0] PULSE_A212_CYC = 13'((PULSE_A212_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [12:0] PULSE_A424_CYC = 13'((PULSE_A424_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [12:0] PULSE_A848_CYC = 13'((PULSE_A848_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // no-response presets in 37.76 us steps: 755 us, 1812 us, 529 us
    localparam logic [7:0] NO_RESP_VIC_HIGH = 8'h14;
    localparam logic [7:0] NO_RESP_VIC_LOW = 8'h30;
    localparam logic [7:0] NO_RESP_OTHER = 8'h0E;

endpackage

//--- src/step_timer.sv
// down counter of whole steps, each step a programmable number of clocks
// assumes start, stop and length come from logic on the same clock
`timescale 1ns/1ps
module step_timer
    import rtt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic start,          // load length and run
    input wire logic stop,           // abandon the count
    input wire logic [13:0] length,  // whole steps, zero never starts
    input wire logic [15:0] step_cyc,
    output logic busy,
    output logic expired             // one-cycle pulse
);

    logic [15:0] prescale;   // clocks left in the current step
    logic [13:0] steps;      // steps left

    // =====================================================
    // counting; stop wins over a start in the same cycle
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy <= 1'b0;
            expired <= 1'b0;
            prescale <= 16'h0000;
            steps <= 14'h0000;
        end
        else
        begin
            expired <= 1'b0;
            if (stop)
            begin
                busy <= 1'b0;
            end
            else if (start && length != 14'h0000)
            begin
                busy <= 1'b1;
                steps <= length;
                prescale <= step_cyc - 16'h0001;
            end
            else if (busy)
            begin
                if (prescale != 16'h0000)
                begin
                    prescale <= prescale - 16'h0001;
                end
                else if (steps == 14'h0001)
                begin
                    // last step done
                    busy <= 1'b0;
                    expired <= 1'b1;
                end
                else
                begin
                    steps <= steps - 14'h0001;
                    prescale <= step_cyc - 16'h0001;
                end
            end
        end
    end

endmodule // step_timer

//--- src/pulse_shaper.sv
// holds the modulation output high for a given number of clocks
// assumes fire is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module pulse_shaper
    import rtt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic fire,
    input wire logic [12:0] width_cyc,
    output logic mod_out
);

    logic [12:0] left;   // clocks still to hold

    // =====================================================
    // a new fire restarts the pulse at its full width
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mod_out <= 1'b0;
            left <= 13'h0000;
        end
        else if (fire && width_cyc != 13'h0000)
        begin
            mod_out <= 1'b1;
            left <= width_cyc - 13'h0001;
        end
        else if (left != 13'h0000)
        begin
            left <= left - 13'h0001;
        end
        else
        begin
            mod_out <= 1'b0;
        end
    end

endmodule // pulse_shaper

//--- test/rtt_checker.sv
// assertions on the timing block ports
// assumes a bind onto reader_tx_rx_timing
`timescale 1ns/1ps
module rtt_checker
#(
    parameter int NO_RESP_STEP_CYC = 4
)
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_mod_request,
    input wire logic delayed_tx_start,
    input wire logic tx_mod_pulse,
    input wire logic irq
);
    // =========================
    // one domain, one default
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_ack_on_req: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == 8'h0 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    // a length of at least one step keeps starts far apart
    a_start_spaced: assert property (
        delayed_tx_start |=> !delayed_tx_start [*8])
        else $error("delayed start too close");
    a_pulse_cause: assert property ($rose(tx_mod_pulse) |-> $past(tx_mod_request))
        else $error("pulse without request");
    a_pulse_min_len: assert property ($rose(tx_mod_pulse) |-> tx_mod_pulse [*8])
        else $error("pulse too short");
    c_delay: cover property (delayed_tx_start);
    c_pulse: cover property ($rose(tx_mod_pulse));
    c_irq: cover property ($rose(irq));
endmodule // rtt_checker

bind reader_tx_rx_timing rtt_checker #(.NO_RESP_STEP_CYC(NO_RESP_STEP_CYC)) rtt_checker_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_mod_request(tx_mod_request), .delayed_tx_start(delayed_tx_start),
    .tx_mod_pulse(tx_mod_pulse), .irq(irq));

//--- test/host_bus_model.sv
// host side: classic wishbone master
// assumes a slave with registered ack
`timescale 1ns/1ps
module host_bus_model
(
    input wire logic clk_sys,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    // idle bus from time zero
    initial
    begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end
    // held until ack; only the bench watchdog ends a hung wait
    task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clk_sys);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, we, a, 4'hF, 24'h0, d};
        do
        begin
            @(posedge clk_sys);
        end
        while (ack_i !== 1'b1);
        q = dat_i;
        {cyc_o, stb_o} <= 2'b00;
    endtask
    // fifo reset command after tx complete
    task automatic fifo_reset;
        logic [31:0] q;
        xfer(1'b1, 8'h38, 8'h0F, q);
    endtask
endmodule // host_bus_model

//--- test/reader_tx_rx_timing_test.sv
// self-checking bench for the reader timing block
// assumes host_bus_model and the bound checker
`timescale 1ns/1ps
module reader_tx_rx_timing_test;
    localparam int NRS = 4;  // short silence step
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic chip_enable = 1'b1;
    logic [6:0] ev = '0;  // event pulses, bit 6 pulse request
    logic cyc, stb, we, ack, dts, mod, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rd, q;
    logic [31:0] seed = 32'h7095_ef6e;
    int err_count = 0;
    int total_checks = 0;
    int n, len;
    // preset pulse clocks, ns over 4 rounded up
    int pw[6] = '{2360, 2360, 590, 350, 185, 111};
    reader_tx_rx_timing #(.NO_RESP_STEP_CYC(NRS)) reader_tx_rx_timing_inst (
        .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
        .wb_ack_o(ack), .chip_enable(chip_enable), .tx_sof_begin(ev[0]),
        .tx_sof_end(ev[1]), .rx_sof_begin(ev[2]), .rx_sof_end(ev[3]), .tx_eof_end(ev[4]),
        .tx_complete(ev[5]), .tx_mod_request(ev[6]), .delayed_tx_start(dts),
        .tx_mod_pulse(mod), .irq(irq));
    host_bus_model host_bus_model_inst (.clk_sys(clk_sys), .ack_i(ack), .dat_i(rd),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
    initial forever #2 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk_val(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        err_count += (g !== e);
        if (g !== e) $display("mismatch %s expected %h seen %h", s, e, g);
    endtask
    task automatic chk_cnt(input string s, input int e, input int g);
        total_checks++;
        err_count += (g != e);
        if (g != e) $display("mismatch %s expected %0d seen %0d", s, e, g);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_bus_model_inst.xfer(1'b1, a, d, q);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
        host_bus_model_inst.xfer(1'b0, a, 8'h0, q);
        chk_val(s, e, q);
    endtask
    // irq is registered, so let two edges pass
    task automatic chk_irq(input logic [31:0] e);
        repeat (2) @(posedge clk_sys);
        chk_val("irq", e, 32'(irq));
    endtask
    task automatic fire(input int k);
        @(posedge clk_sys);
        ev <= 7'(1) << k;
        @(posedge clk_sys);
        ev <= '0;
    endtask
    // edges until the chosen output is high, or lim
    task automatic wt(input bit on_irq, input int lim, output int c);
        c = 0;
        do
        begin
            @(posedge clk_sys);
            c++;
        end
        while ((on_irq ? irq : dts) !== 1'b1 && c < lim);
    endtask
    task automatic pulse(output int c);
        c = 0;
        fire(6);
        repeat (2400)
        begin
            @(posedge clk_sys);
            c += (mod === 1'b1);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rc(8'h14, 32'h0, "dlo");
        rc(8'h18, 32'h0, "pul");
        rc(8'h1C, 32'hE, "nor");
        rc(8'h00, 32'h0, "unm");
        // delay from end of tx sof, random length, event masked at first
        seed = lfsr(seed);
        len = int'(seed[1:0]) + 1;
        wr(8'h34, 8'h01);
        wr(8'h10, 8'h40);
        wr(8'h14, 8'(len));
        fire(1);
        wt(1'b0, 1000, n);
        chk_cnt("dly", len * 148 + 2, n);
        rc(8'h30, 32'h2, "st");
        chk_irq(32'h0);
        wr(8'h34, 8'h03);
        chk_irq(32'h1);
        wr(8'h30, 8'h02);
        chk_irq(32'h0);
        wr(8'h14, 8'h00);
        fire(1);
        wt(1'b0, 600, n);
        chk_cnt("zero", 600, n);
        // protocol codes 0 to 5, delay low register dirtied first
        for (int p = 0; p < 6; p++)
        begin
            wr(8'h14, 8'hA5);
            wr(8'h04, 8'(p));
            rc(8'h14, 32'h0, "dlo");
            rc(8'h1C, p == 0 ? 32'h30 : p == 1 ? 32'h14 : 32'hE, "nor");
            pulse(n);
            chk_cnt("pre", pw[p], n);
        end
        seed = lfsr(seed);
        len = int'(seed[3:0]) + 1;
        wr(8'h04, 8'h02);
        wr(8'h18, 8'(len));
        pulse(n);
        chk_cnt("ovr", len * 19, n);
        wr(8'h04, 8'h05);
        wr(8'h18, 8'(len));
        pulse(n);
        chk_cnt("ovd", pw[5], n);
        chip_enable <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chip_enable <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rc(8'h18, 32'h0, "dis");
        // vicinity, five steps of silence
        wr(8'h04, 8'h00);
        wr(8'h1C, 8'h05);
        fire(4);
        wt(1'b1, 200, n);
        chk_cnt("sil", 1, int'(n >= 5 * NRS && n <= 5 * NRS + 6));
        rc(8'h30, 32'h1, "st");
        wr(8'h30, 8'h01);
        fire(4);
        fire(2);
        wt(1'b1, 60, n);
        chk_cnt("ans", 60, n);
        fire(5);
        host_bus_model_inst.fifo_reset();
        fire(4);
        wt(1'b1, 60, n);
        chk_cnt("off", 60, n);
        fire(0);
        wr(8'h04, 8'h02);
        wr(8'h1C, 8'h05);
        fire(4);
        wt(1'b1, 60, n);
        chk_cnt("tya", 60, n);
        give_verdict();
    end
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        give_verdict();
    end
endmodule // reader_tx_rx_timing_test
